// ===== rtl/vf_monitor_pkg.sv
// Constants and carrier types for the V/f curve and input phase-loss monitor.
// Frequencies are in 0.1 Hz, voltages in 0.1 V, all settings arrive on the system clock.
package vf_monitor_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned WINDOW_MS = 1280;
    localparam int unsigned FAULT_DELAY_MS = 10240;
    localparam longint unsigned WINDOW_CYCLES = (longint'(WINDOW_MS) * CLK_HZ) / 1000;
    localparam longint unsigned FAULT_DELAY_CYCLES = (longint'(FAULT_DELAY_MS) * CLK_HZ) / 1000;

    localparam logic [1:0] CURVE_CUSTOM = 2'h0;
    localparam logic [1:0] CURVE_PRESET = 2'h1;

    // Preset curve, 0.1 Hz / 0.1 V
    localparam logic [15:0] PRESET_TOP_F = 16'h0258;
    localparam logic [15:0] PRESET_TOP_V = 16'h08FC;
    localparam logic [15:0] PRESET_FULL_F = 16'h0258;
    localparam logic [15:0] PRESET_MID_F = 16'h001E;
    localparam logic [15:0] PRESET_MID_V = 16'h00AC;
    localparam logic [15:0] PRESET_BOT_F = 16'h000F;
    localparam logic [15:0] PRESET_BOT_V = 16'h0073;
    // Custom curve factory defaults
    localparam logic [15:0] CUSTOM_TOP_F = 16'h0258;
    localparam logic [15:0] CUSTOM_TOP_V = 16'h08FC;
    localparam logic [15:0] CUSTOM_FULL_F = 16'h0258;
    localparam logic [15:0] CUSTOM_MID_F = 16'h012C;
    localparam logic [15:0] CUSTOM_MID_V = 16'h023F;
    localparam logic [15:0] CUSTOM_BOT_F = 16'h000F;
    localparam logic [15:0] CUSTOM_BOT_V = 16'h0073;

    // Motor rated voltage: preset reference and accepted range per unit class
    localparam logic [15:0] REF_VOLTAGE = 16'h08FC;
    localparam logic [15:0] RATED_V_MIN = 16'h05DC;
    localparam logic [15:0] RATED_V_MAX_230 = 16'h09F6;
    localparam logic [15:0] RATED_V_MAX_460 = 16'h13EC;
    localparam logic [15:0] RATED_V_MAX_575 = 16'h1CA3;
    localparam logic [15:0] RATED_V_RESET = 16'h08FC;
    localparam logic [1:0] CLASS_230 = 2'h0;
    localparam logic [1:0] CLASS_460 = 2'h1;

    localparam logic [6:0] LEVEL_MIN = 7'h01;
    localparam logic [6:0] LEVEL_MAX = 7'h64;
    localparam logic [6:0] LEVEL_RESET = 7'h07;
    localparam logic [6:0] CURRENT_FLOOR_PCT = 7'h1E;
    localparam logic [6:0] PERCENT_FULL = 7'h64;

    typedef struct packed {
        logic [15:0] top_frequency;
        logic [15:0] top_voltage;
        logic [15:0] full_voltage_frequency;
        logic [15:0] mid_frequency;
        logic [15:0] mid_voltage;
        logic [15:0] bottom_frequency;
        logic [15:0] bottom_voltage;
    } curve_t;

    localparam curve_t PRESET_CURVE = '{PRESET_TOP_F, PRESET_TOP_V, PRESET_FULL_F,
        PRESET_MID_F, PRESET_MID_V, PRESET_BOT_F, PRESET_BOT_V};
    localparam curve_t CUSTOM_CURVE = '{CUSTOM_TOP_F, CUSTOM_TOP_V, CUSTOM_FULL_F,
        CUSTOM_MID_F, CUSTOM_MID_V, CUSTOM_BOT_F, CUSTOM_BOT_V};

    // Gray codes along idle -> watch -> pending -> fault
    typedef enum logic [1:0] {
        PL_IDLE = 2'b00,
        PL_WATCH = 2'b01,
        PL_PENDING = 2'b11,
        PL_FAULT = 2'b10
    } loss_state_t;
endpackage

// ===== rtl/vf_curve_and_phase_loss_monitor.sv
// V/f output curve and input phase-loss supervisor, one clock domain.
// Assumes settings, keypad strobes, bus samples and drive status come from logic on ref_clk.
// Behaviour
// - Preset select forces breakpoints to preset values and refuses breakpoint changes; rated voltage and level are still accepted.
// - Preset breakpoints are 60 Hz, 230 V, 60 Hz, 3 Hz/17.2 V, 1.5 Hz/11.5 V.
// - Breakpoint settings shape the curve with any select other than preset.
// - Custom defaults: 60 Hz, 230 V, 60 Hz, 30 Hz/57.5 V, 1.5 Hz/11.5 V.
// - Motor rated voltage accepted from 150.0 V up to the unit class limit.
// - Preset voltages are scaled by motor rated voltage over 230 V.
// - In custom mode motor rated voltage has no effect on output.
// - Midpoint frequency equal to minimum gives one straight segment, midpoint voltage ignored.
// - Settings are checked at power-up and each confirmed entry in programming mode.
// - Curve error unless frequencies and voltages are ordered non-increasing from the top.
// - Phase-loss level accepts 1 to 100 percent, default 7.
// - Bus voltage max and min tracked per 1.28 s window, difference compared.
// - Difference at or above level registers loss; fault and coast after 10.24 s.
// - Detection inhibited at level 100, stop, contactor off or converter fault.
// - Detection inhibited while accelerating or current at or below 30 percent.
`timescale 1ns/1ps
`default_nettype none
module vf_curve_and_phase_loss_monitor #(
    parameter longint unsigned WINDOW_CYCLES = vf_monitor_pkg::WINDOW_CYCLES,
    parameter longint unsigned FAULT_DELAY_CYCLES = vf_monitor_pkg::FAULT_DELAY_CYCLES,
    parameter logic [15:0] BUS_NOMINAL = 16'h0BB8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] curve_select,
    input wire vf_monitor_pkg::curve_t curve_in,
    input wire logic [15:0] motor_rated_voltage,
    input wire logic [1:0] voltage_class,
    input wire logic [6:0] phase_loss_level,
    input wire logic setting_write,
    input wire logic programming_mode,
    input wire logic [15:0] output_frequency,
    input wire logic [15:0] bus_voltage,
    input wire logic bus_sample_valid,
    input wire logic stop_command,
    input wire logic main_contactor,
    input wire logic converter_fault,
    input wire logic accelerating,
    input wire logic [15:0] output_current,
    input wire logic [15:0] drive_rated_current,
    input wire logic fault_reset,
    output logic [15:0] output_voltage,
    output logic curve_setting_error,
    output logic phase_loss_pending,
    output logic phase_loss_fault,
    output logic output_shutoff
);
    vf_monitor_pkg::curve_t bp;
    logic [15:0] rated_v, bus_max, bus_min, next_voltage;
    logic [6:0] level;
    logic check_pending, preset_mode, inhibit, window_end, loss_seen;
    logic [31:0] window_count, delay_count;
    vf_monitor_pkg::loss_state_t state;

    // Voltage on the segment (fa,va)-(fb,vb); a falling or empty segment holds its end value
    function automatic logic [15:0] interp(input logic [15:0] f, input logic [15:0] fa,
                                           input logic [15:0] va, input logic [15:0] fb,
                                           input logic [15:0] vb);
        logic [31:0] span;
        if (fb <= fa || vb < va || f >= fb) begin
            interp = vb;
        end else begin
            span = (32'(f - fa) * 32'(vb - va)) / 32'(fb - fa);
            interp = va + span[15:0];
        end
    endfunction

    function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] mrv);
        logic [31:0] prod;
        prod = (32'(v) * 32'(mrv)) / 32'(vf_monitor_pkg::REF_VOLTAGE);
        scale = prod[15:0];
    endfunction

    function automatic logic [15:0] rated_limit(input logic [1:0] cls);
        rated_limit = (cls == vf_monitor_pkg::CLASS_230) ? vf_monitor_pkg::RATED_V_MAX_230 :
                      (cls == vf_monitor_pkg::CLASS_460) ? vf_monitor_pkg::RATED_V_MAX_460 :
                      vf_monitor_pkg::RATED_V_MAX_575;
    endfunction

    function automatic logic ordered(input vf_monitor_pkg::curve_t c);
        ordered = c.top_frequency >= c.full_voltage_frequency &&
                  c.full_voltage_frequency >= c.mid_frequency &&
                  c.mid_frequency >= c.bottom_frequency &&
                  c.top_voltage >= c.mid_voltage && c.mid_voltage >= c.bottom_voltage;
    endfunction

    assign preset_mode = (curve_select == vf_monitor_pkg::CURVE_PRESET);

    // Breakpoint store; preset mode pins it so a later switch to custom starts from the preset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp <= vf_monitor_pkg::CUSTOM_CURVE;
        end else if (preset_mode) begin
            bp <= vf_monitor_pkg::PRESET_CURVE;
        end else if (setting_write) begin
            bp <= curve_in;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rated_v <= vf_monitor_pkg::RATED_V_RESET;
        end else if (setting_write && motor_rated_voltage >= vf_monitor_pkg::RATED_V_MIN &&
                     motor_rated_voltage <= rated_limit(voltage_class)) begin
            rated_v <= motor_rated_voltage;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= vf_monitor_pkg::LEVEL_RESET;
        end else if (setting_write && phase_loss_level >= vf_monitor_pkg::LEVEL_MIN &&
                     phase_loss_level <= vf_monitor_pkg::LEVEL_MAX) begin
            level <= phase_loss_level;
        end
    end

    // Check runs one cycle after the store settles, so it sees the values now in force
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            check_pending <= 1'b1;
            curve_setting_error <= 1'b0;
        end else begin
            check_pending <= setting_write && programming_mode;
            if (check_pending) begin
                curve_setting_error <= !ordered(bp);
            end
        end
    end

    // Below the bottom point is decided ahead of every segment, so no segment sees a frequency left of its start
    always_comb begin
        if (output_frequency >= bp.full_voltage_frequency) begin
            next_voltage = bp.top_voltage;
        end else if (output_frequency < bp.bottom_frequency) begin
            next_voltage = bp.bottom_voltage;
        end else if (bp.mid_frequency == bp.bottom_frequency) begin
            next_voltage = interp(output_frequency, bp.bottom_frequency, bp.bottom_voltage,
                                  bp.full_voltage_frequency, bp.top_voltage);
        end else if (output_frequency >= bp.mid_frequency) begin
            next_voltage = interp(output_frequency, bp.mid_frequency, bp.mid_voltage,
                                  bp.full_voltage_frequency, bp.top_voltage);
        end else begin
            next_voltage = interp(output_frequency, bp.bottom_frequency, bp.bottom_voltage,
                                  bp.mid_frequency, bp.mid_voltage);
        end
    end

    // Scaling after interpolation equals scaling each breakpoint, since the map is linear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_voltage <= 16'h0000;
        end else if (output_shutoff) begin
            output_voltage <= 16'h0000;
        end else if (preset_mode) begin
            output_voltage <= scale(next_voltage, rated_v);
        end else begin
            output_voltage <= next_voltage;
        end
    end

    always_comb begin
        inhibit = level == vf_monitor_pkg::LEVEL_MAX || stop_command || !main_contactor ||
                  converter_fault;
        if (accelerating || 32'(output_current) * 32'(vf_monitor_pkg::PERCENT_FULL) <=
            32'(drive_rated_current) * 32'(vf_monitor_pkg::CURRENT_FLOOR_PCT)) begin
            inhibit = 1'b1;
        end
    end

    assign window_end = (64'(window_count) >= WINDOW_CYCLES - 64'd1);
    // Level is a percentage of the nominal bus voltage
    assign loss_seen = 32'(bus_max - bus_min) * 32'(vf_monitor_pkg::PERCENT_FULL) >=
                       32'(level) * 32'(BUS_NOMINAL);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            window_count <= 32'h00000000;
            bus_max <= 16'h0000;
            bus_min <= 16'hFFFF;
        end else if (state != vf_monitor_pkg::PL_WATCH || window_end) begin
            window_count <= 32'h00000000;
            bus_max <= 16'h0000;
            bus_min <= 16'hFFFF;
        end else begin
            window_count <= window_count + 32'h00000001;
            if (bus_sample_valid && bus_voltage > bus_max) begin
                bus_max <= bus_voltage;
            end
            if (bus_sample_valid && bus_voltage < bus_min) begin
                bus_min <= bus_voltage;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= vf_monitor_pkg::PL_IDLE;
            delay_count <= 32'h00000000;
        end else begin
            case (state)
                vf_monitor_pkg::PL_IDLE: begin
                    if (!inhibit) begin
                        state <= vf_monitor_pkg::PL_WATCH;
                    end
                end
                vf_monitor_pkg::PL_WATCH: begin
                    if (inhibit) begin
                        state <= vf_monitor_pkg::PL_IDLE;
                    end else if (window_end && bus_max >= bus_min && loss_seen) begin
                        state <= vf_monitor_pkg::PL_PENDING;
                        delay_count <= 32'h00000000;
                    end
                end
                vf_monitor_pkg::PL_PENDING: begin
                    if (inhibit) begin
                        state <= vf_monitor_pkg::PL_IDLE;
                    end else if (64'(delay_count) >= FAULT_DELAY_CYCLES - 64'd1) begin
                        state <= vf_monitor_pkg::PL_FAULT;
                    end else begin
                        delay_count <= delay_count + 32'h00000001;
                    end
                end
                default: begin
                    if (fault_reset) begin
                        state <= vf_monitor_pkg::PL_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_loss_pending <= 1'b0;
            phase_loss_fault <= 1'b0;
            output_shutoff <= 1'b0;
        end else begin
            phase_loss_pending <= state == vf_monitor_pkg::PL_PENDING;
            phase_loss_fault <= state == vf_monitor_pkg::PL_FAULT;
            output_shutoff <= state == vf_monitor_pkg::PL_FAULT;
        end
    end

    property p_preset_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        preset_mode |=> bp == vf_monitor_pkg::PRESET_CURVE;
    endproperty
    a_preset_hold: assert property (p_preset_hold) else $error("preset curve not held");
    property p_check_flags;
        @(posedge ref_clk) disable iff (!rst_n)
        check_pending ##1 1'b1 |-> curve_setting_error == !ordered($past(bp));
    endproperty
    a_check_flags: assert property (p_check_flags) else $error("curve error flag wrong");
    property p_entry_checks;
        @(posedge ref_clk) disable iff (!rst_n)
        setting_write && programming_mode |=> check_pending;
    endproperty
    a_entry_checks: assert property (p_entry_checks) else $error("entry not checked");
    property p_level_range;
        @(posedge ref_clk) disable iff (!rst_n)
        level >= vf_monitor_pkg::LEVEL_MIN && level <= vf_monitor_pkg::LEVEL_MAX;
    endproperty
    a_level_range: assert property (p_level_range) else $error("level out of range");
    property p_rated_range;
        @(posedge ref_clk) disable iff (!rst_n)
        rated_v >= vf_monitor_pkg::RATED_V_MIN && rated_v <= vf_monitor_pkg::RATED_V_MAX_575;
    endproperty
    a_rated_range: assert property (p_rated_range) else $error("rated voltage out of range");
    property p_fault_after_pending;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(phase_loss_fault) |-> $past(state, 2) == vf_monitor_pkg::PL_PENDING && output_shutoff;
    endproperty
    a_fault_after_pending: assert property (p_fault_after_pending) else $error("fault without delay");
    property p_inhibit_stops;
        @(posedge ref_clk) disable iff (!rst_n)
        inhibit && (state == vf_monitor_pkg::PL_WATCH || state == vf_monitor_pkg::PL_PENDING)
        |=> state == vf_monitor_pkg::PL_IDLE;
    endproperty
    a_inhibit_stops: assert property (p_inhibit_stops) else $error("detection not inhibited");
    property p_custom_top;
        @(posedge ref_clk) disable iff (!rst_n)
        !preset_mode && !output_shutoff && output_frequency >= bp.full_voltage_frequency
        |=> output_voltage == $past(bp.top_voltage);
    endproperty
    a_custom_top: assert property (p_custom_top) else $error("top voltage not held");
    property p_window_loss;
        @(posedge ref_clk) disable iff (!rst_n)
        state == vf_monitor_pkg::PL_WATCH && !inhibit && window_end && bus_max >= bus_min && loss_seen
        |=> state == vf_monitor_pkg::PL_PENDING ##1 phase_loss_pending;
    endproperty
    a_window_loss: assert property (p_window_loss) else $error("loss not registered");
endmodule
`default_nettype wire

// ===== tb/vf_curve_and_phase_loss_monitor_tb_top.sv
// Self-checking bench for the V/f curve and phase-loss monitor.
// Assumes the design files and package are compiled first; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module vf_curve_and_phase_loss_monitor_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] curve_select = 2'h0;
    vf_monitor_pkg::curve_t curve_in = vf_monitor_pkg::CUSTOM_CURVE;
    logic [15:0] motor_rated_voltage = 16'h08FC;
    logic [1:0] voltage_class = 2'h0;
    logic [6:0] phase_loss_level = 7'h07;
    logic setting_write = 1'b0;
    logic programming_mode = 1'b0;
    logic [15:0] output_frequency = 16'h0000;
    logic [15:0] bus_voltage = 16'h0BB8;
    logic bus_sample_valid = 1'b1;
    logic stop_command = 1'b1;
    logic main_contactor = 1'b0;
    logic converter_fault = 1'b0;
    logic accelerating = 1'b0;
    logic [15:0] output_current = 16'h0000;
    logic [15:0] drive_rated_current = 16'h0064;
    logic fault_reset = 1'b0;
    logic [15:0] output_voltage;
    logic curve_setting_error;
    logic phase_loss_pending;
    logic phase_loss_fault;
    logic output_shutoff;
    logic [15:0] amp = 16'h0000;
    logic flip = 1'b0;
    int n_fail = 0;
    int n_tests = 0;

    vf_curve_and_phase_loss_monitor #(.WINDOW_CYCLES(16), .FAULT_DELAY_CYCLES(32), .BUS_NOMINAL(16'h0BB8))
    vf_curve_and_phase_loss_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n), .curve_select(curve_select),
        .curve_in(curve_in), .motor_rated_voltage(motor_rated_voltage), .voltage_class(voltage_class),
        .phase_loss_level(phase_loss_level), .setting_write(setting_write), .programming_mode(programming_mode),
        .output_frequency(output_frequency), .bus_voltage(bus_voltage), .bus_sample_valid(bus_sample_valid),
        .stop_command(stop_command), .main_contactor(main_contactor), .converter_fault(converter_fault),
        .accelerating(accelerating), .output_current(output_current), .drive_rated_current(drive_rated_current),
        .fault_reset(fault_reset), .output_voltage(output_voltage), .curve_setting_error(curve_setting_error),
        .phase_loss_pending(phase_loss_pending), .phase_loss_fault(phase_loss_fault),
        .output_shutoff(output_shutoff));

    always #4 ref_clk = ~ref_clk;

    // Bus ripple of peak-to-peak amp above the nominal level
    always @(negedge ref_clk) begin
        flip <= ~flip;
        bus_voltage <= flip ? 16'h0BB8 + amp : 16'h0BB8;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic vf_monitor_pkg::curve_t mk(input logic [15:0] tf, tv, ff, mf, mv, bf, bv);
        return '{tf, tv, ff, mf, mv, bf, bv};
    endfunction

    task automatic put(input vf_monitor_pkg::curve_t c, input logic [15:0] rv, input logic [1:0] cls,
                       input logic [6:0] lvl, input logic prog);
        curve_in = c;
        motor_rated_voltage = rv;
        voltage_class = cls;
        phase_loss_level = lvl;
        programming_mode = prog;
        setting_write = 1'b1;
        tick(1);
        setting_write = 1'b0;
        tick(3);
        programming_mode = 1'b0;
    endtask

    task automatic volt_at(input logic [15:0] f, input logic [15:0] exp);
        output_frequency = f;
        tick(3);
        check("output_voltage", output_voltage, exp);
    endtask

    task automatic wait_flag(input bit want_fault, input int lim);
        for (int k = 0; k < lim; k++) begin
            if ((want_fault ? phase_loss_fault : phase_loss_pending) === 1'b1) begin
                return;
            end
            tick(1);
        end
    endtask

    task automatic t_reset();
        tick(3);
        check("reset voltage", output_voltage, 16'h0000);
        check("reset flags", {12'h000, curve_setting_error, phase_loss_pending, phase_loss_fault, output_shutoff}, 16'h0000);
        tick(2);
        rst_n = 1'b1;
        tick(3);
        check("power-up check", {15'h0000, curve_setting_error}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_custom();
        volt_at(16'h0258, 16'h08FC);
        volt_at(16'h012C, 16'h023F);
        volt_at(16'h000F, 16'h0073);
        volt_at(16'h0190, 16'h047E);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h11F8, 2'h1, 7'h07, 1'b0);
        volt_at(16'h0258, 16'h08FC);
        volt_at(16'h012C, 16'h023F);
        $display("test custom done");
    endtask

    task automatic t_preset();
        curve_select = 2'h1;
        put(mk(16'h0200, 16'h0800, 16'h0200, 16'h0100, 16'h0400, 16'h0020, 16'h0100), 16'h08FC, 2'h0, 7'h07, 1'b0);
        volt_at(16'h001E, 16'h00AC);
        volt_at(16'h000F, 16'h0073);
        volt_at(16'h0258, 16'h08FC);
        volt_at(16'h013B, 16'h04D4);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h11F8, 2'h1, 7'h07, 1'b0);
        volt_at(16'h001E, 16'h0158);
        volt_at(16'h0258, 16'h11F8);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h0578, 2'h1, 7'h07, 1'b0);
        volt_at(16'h0258, 16'h11F8);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h0A00, 2'h0, 7'h07, 1'b0);
        volt_at(16'h0258, 16'h11F8);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h09F6, 2'h0, 7'h07, 1'b0);
        volt_at(16'h0258, 16'h09F6);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h1CA3, 2'h2, 7'h07, 1'b0);
        volt_at(16'h0258, 16'h1CA3);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h1CA4, 2'h2, 7'h07, 1'b0);
        volt_at(16'h0258, 16'h1CA3);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h07, 1'b0);
        $display("test preset done");
    endtask

    task automatic t_straight();
        curve_select = 2'h0;
        put(mk(16'h0258, 16'h08FC, 16'h0258, 16'h0096, 16'h07D0, 16'h0096, 16'h0073), 16'h11F8, 2'h1, 7'h07, 1'b0);
        volt_at(16'h00F0, 16'h0228);
        volt_at(16'h0258, 16'h08FC);
        $display("test straight done");
    endtask

    task automatic t_check();
        put(mk(16'h0258, 16'h08FC, 16'h0258, 16'h0300, 16'h023F, 16'h000F, 16'h0073), 16'h08FC, 2'h0, 7'h07, 1'b1);
        check("freq order", {15'h0000, curve_setting_error}, 16'h0001);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h07, 1'b0);
        check("no check outside prog", {15'h0000, curve_setting_error}, 16'h0001);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h07, 1'b1);
        check("good curve", {15'h0000, curve_setting_error}, 16'h0000);
        put(mk(16'h0258, 16'h08FC, 16'h0258, 16'h012C, 16'h0900, 16'h000F, 16'h0073), 16'h08FC, 2'h0, 7'h07, 1'b1);
        check("volt order", {15'h0000, curve_setting_error}, 16'h0001);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h07, 1'b1);
        check("restored", {15'h0000, curve_setting_error}, 16'h0000);
        $display("test check done");
    endtask

    task automatic normal();
        stop_command = 1'b0;
        main_contactor = 1'b1;
        converter_fault = 1'b0;
        accelerating = 1'b0;
        output_current = 16'h0064;
    endtask

    task automatic t_phase();
        amp = 16'h012C;
        for (int i = 0; i < 6; i++) begin
            normal();
            case (i)
                0: stop_command = 1'b1;
                1: main_contactor = 1'b0;
                2: converter_fault = 1'b1;
                3: accelerating = 1'b1;
                4: output_current = 16'h001E;
                default: put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h64, 1'b0);
            endcase
            tick(80);
            check("inhibited", {15'h0000, phase_loss_pending}, 16'h0000);
        end
        // Ripple set before detection resumes, so the first window sees only this amplitude
        amp = 16'h00D2;
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h07, 1'b0);
        put(vf_monitor_pkg::CUSTOM_CURVE, 16'h08FC, 2'h0, 7'h65, 1'b0);
        normal();
        wait_flag(1'b0, 60);
        check("at level", {15'h0000, phase_loss_pending}, 16'h0001);
        accelerating = 1'b1;
        amp = 16'h00C8;
        tick(4);
        check("cancel", {15'h0000, phase_loss_pending}, 16'h0000);
        accelerating = 1'b0;
        tick(80);
        check("below level", {15'h0000, phase_loss_pending}, 16'h0000);
        bus_sample_valid = 1'b0;
        amp = 16'h012C;
        tick(80);
        check("invalid samples", {15'h0000, phase_loss_pending}, 16'h0000);
        bus_sample_valid = 1'b1;
        amp = 16'h012C;
        wait_flag(1'b0, 60);
        check("pending", {15'h0000, phase_loss_pending}, 16'h0001);
        tick(20);
        check("early fault", {15'h0000, phase_loss_fault}, 16'h0000);
        wait_flag(1'b1, 30);
        check("fault", {14'h0000, phase_loss_fault, output_shutoff}, 16'h0003);
        output_frequency = 16'h0258;
        tick(3);
        check("coast", output_voltage, 16'h0000);
        amp = 16'h0000;
        fault_reset = 1'b1;
        tick(2);
        fault_reset = 1'b0;
        tick(2);
        check("cleared", {15'h0000, phase_loss_fault}, 16'h0000);
        $display("test phase loss done");
    endtask

    initial begin
        #100000;
        n_fail++;
        final_report();
    end

    initial begin
        t_reset();
        t_custom();
        t_preset();
        t_straight();
        t_check();
        t_phase();
        final_report();
    end
endmodule
`default_nettype wire
